// >>> dicond_top.v
// digital input conditioner: parameter decode, eight channels, input bytes, apb registers
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "dicond_consts.vh"
module dicond_top (
  input wire CORE_CLK,
  input wire SYS_RST,
  input wire [7:0] DIN,
  input wire [7:0] LINE_FAULT,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  output reg [7:0] IN_BYTE1,
  output reg [7:0] IN_BYTE2,
  output reg IN_STROBE,
  output reg [7:0] CFG_CODE
);
  ////////////////////////////////////////////////////////////////
  // input synchronisers: change counts once stages two and three agree
  reg [7:0] din_s1, din_s2, din_s3, din_q;
  reg [7:0] flt_s1, flt_s2, flt_s3, flt_q;
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      din_s1 <= 8'h00;
      din_s2 <= 8'h00;
      din_s3 <= 8'h00;
      din_q <= 8'h00;
      flt_s1 <= 8'h00;
      flt_s2 <= 8'h00;
      flt_s3 <= 8'h00;
      flt_q <= 8'h00;
    end else begin
      din_s1 <= DIN;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
      din_q <= (din_s2 & din_s3) | (din_q & (din_s2 | din_s3));
      flt_s1 <= LINE_FAULT;
      flt_s2 <= flt_s1;
      flt_s3 <= flt_s2;
      flt_q <= (flt_s2 & flt_s3) | (flt_q & (flt_s2 | flt_s3));
    end
  end

  ////////////////////////////////////////////////////////////////
  // time bases
  reg [17:0] tick_cnt;
  reg ms_tick;
  reg [21:0] ref_cnt;
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      tick_cnt <= 18'h00000;
      ms_tick <= 1'b0;
    end else if (tick_cnt == `DICOND_TICK_CYC - 1) begin
      tick_cnt <= 18'h00000;
      ms_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 18'd1;
      ms_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // parameter telegram reception, one byte per write to the telegram register
  localparam ST_IDLE = 2'd0;
  localparam ST_EIGHT = 2'd1;
  localparam ST_SEVEN = 2'd2;
  reg [1:0] state;
  reg [3:0] idx;
  reg [7:0] cfg_mem [0:7];
  reg [7:0] stage [0:7];
  reg [7:0] seven_lfd;
  reg mode_seven;
  reg prm_ok;
  reg prm_err;
  integer i;
  integer j;

  wire acc = PSEL & PENABLE & PREADY;
  wire wr = acc & PWRITE;
  wire prm_wr = wr && PADDR == `DICOND_ADDR_PRM;
  wire [7:0] pb = PWDATA[7:0];

  // type codes 0 proximity, 1 and 2 active
  function type_ok;
    input [7:0] b;
    begin
      // active types refused with fault detection on
      type_ok = b[`DICOND_CH_TYPE_LO +: 2] != `DICOND_TYPE_BAD &&
        (b[`DICOND_CH_TYPE_LO +: 2] == `DICOND_TYPE_PROX || !b[`DICOND_CH_LFD]);
    end
  endfunction

  reg all_ok;
  always @* begin
    all_ok = 1'b1;
    for (j = 0; j < 7; j = j + 1) begin
      if (!type_ok(stage[j])) begin
        all_ok = 1'b0;
      end
    end
  end

  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state <= ST_IDLE;
      idx <= 4'h0;
      seven_lfd <= 8'h00;
      mode_seven <= 1'b0;
      prm_ok <= 1'b0;
      prm_err <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        cfg_mem[i] <= `DICOND_CH_DEFAULT;
        stage[i] <= `DICOND_CH_DEFAULT;
      end
    end else if (wr && PADDR == `DICOND_ADDR_CTRL && PWDATA[0]) begin
      state <= ST_IDLE;
      idx <= 4'h0;
    end else if (prm_wr) begin
      case (state)
        ST_IDLE: begin
          idx <= 4'h0;
          if (pb == `DICOND_ID_EIGHT) begin
            state <= ST_EIGHT;
          end else if (pb == `DICOND_ID_SEVEN) begin
            state <= ST_SEVEN;
          end else begin
            prm_err <= 1'b1;
          end
        end
        ST_EIGHT: begin
          // whole byte is one channel's setting
          stage[idx[2:0]] <= pb;
          idx <= idx + 4'd1;
          if (idx == 4'd7) begin
            state <= ST_IDLE;
            if (all_ok && type_ok(pb)) begin
              for (i = 0; i < 7; i = i + 1) begin
                cfg_mem[i] <= stage[i];
              end
              cfg_mem[7] <= pb;
              mode_seven <= 1'b0;
              prm_ok <= 1'b1;
              prm_err <= 1'b0;
            end else begin
              prm_err <= 1'b1;
            end
          end
        end
        ST_SEVEN: begin
          idx <= idx + 4'd1;
          // bit 7 and second byte ignored
          if (idx == 4'd0) begin
            seven_lfd <= {1'b0, pb[6:0]};
          end
          if (idx == 4'd2) begin
            state <= ST_IDLE;
            if (pb[7:6] != `DICOND_TYPE_BAD && (pb[7:6] == `DICOND_TYPE_PROX || seven_lfd == 8'h00)) begin
              for (i = 0; i < 8; i = i + 1) begin
                cfg_mem[i] <= {pb[7:1], (i < 7) ? seven_lfd[i] : 1'b0};
              end
              mode_seven <= 1'b1;
              prm_ok <= 1'b1;
              prm_err <= 1'b0;
            end else begin
              prm_err <= 1'b1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // channels
  wire [7:0] ch_status;
  wire [7:0] ch_fault;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gch
      dicond_channel u_ch (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .ms_tick(ms_tick),
        .raw_in(din_q[g]),
        .raw_fault(flt_q[g]),
        .cfg(cfg_mem[g]),
        .status(ch_status[g]),
        .fault(ch_fault[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // input bytes and refresh
  function [7:0] pack4;
    input [3:0] st;
    input [3:0] ft;
    begin
      pack4 = {ft[3], st[3], ft[2], st[2], ft[1], st[1], ft[0], st[0]};
    end
  endfunction

  // seven-channel mode leaves channel 8 bits empty
  wire [3:0] hi_mask = mode_seven ? 4'h7 : 4'hF;

  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ref_cnt <= 22'h000000;
      IN_BYTE1 <= 8'h00;
      IN_BYTE2 <= 8'h00;
      IN_STROBE <= 1'b0;
      CFG_CODE <= 8'h00;
    end else begin
      CFG_CODE <= `DICOND_CFG_CODE;
      if (ref_cnt == `DICOND_REFRESH_CYC - 1) begin
        ref_cnt <= 22'h000000;
        IN_STROBE <= 1'b1;
        IN_BYTE1 <= pack4(ch_status[7:4] & hi_mask, ch_fault[7:4] & hi_mask);
        IN_BYTE2 <= pack4(ch_status[3:0], ch_fault[3:0]);
      end else begin
        ref_cnt <= ref_cnt + 22'd1;
        IN_STROBE <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb slave, one wait state
  wire [31:0] flt_word = {24'h000000, ch_fault};
  // status word: [7:0] status, [13:8] receiver flags, [23:16] fault
  wire [31:0] stat_word = {8'h00, flt_word[7:0], 2'b00, state, 1'b0, mode_seven, prm_err, prm_ok, ch_status};
  wire mapped = PADDR == `DICOND_ADDR_CTRL || PADDR == `DICOND_ADDR_PRM || PADDR == `DICOND_ADDR_STAT
    || PADDR == `DICOND_ADDR_CFG || (PADDR >= `DICOND_ADDR_CH0 && PADDR < `DICOND_ADDR_CH0 + 12'h020
    && PADDR[1:0] == 2'b00);
  // channel index counts from the first channel register, not from address zero
  wire [11:0] ch_off = PADDR - `DICOND_ADDR_CH0;
  wire [2:0] ch_idx = ch_off[4:2];

  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (PSEL && PENABLE && !PREADY) begin
      PREADY <= 1'b1;
      PSLVERR <= !mapped || (!PWRITE && PADDR == `DICOND_ADDR_PRM);
      if (!PWRITE) begin
        if (PADDR == `DICOND_ADDR_STAT) begin
          PRDATA <= stat_word;
        end else if (PADDR == `DICOND_ADDR_CFG) begin
          PRDATA <= {24'h000000, `DICOND_CFG_CODE};
        end else if (PADDR >= `DICOND_ADDR_CH0 && mapped) begin
          PRDATA <= {24'h000000, cfg_mem[ch_idx]};
        end else begin
          PRDATA <= 32'h00000000;
        end
      end
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end
endmodule

// >>> dicond_consts.vh
// constants for the digital input conditioner
`ifndef DICOND_CONSTS_VH
`define DICOND_CONSTS_VH
`define DICOND_CFG_CODE 8'h11
`define DICOND_ID_EIGHT 8'h18
`define DICOND_ID_SEVEN 8'h17
`define DICOND_CH_LFD 0
`define DICOND_CH_INV 1
`define DICOND_CH_ON_LO 2
`define DICOND_CH_OFF_LO 4
`define DICOND_CH_TYPE_LO 6
`define DICOND_TYPE_PROX 2'h0
`define DICOND_TYPE_BAD 2'h3
`define DICOND_CH_DEFAULT 8'h00
`define DICOND_CLK_MHZ 250
`define DICOND_TICK_CYC (`DICOND_CLK_MHZ * 1000)
`define DICOND_DLY1_MS 10
`define DICOND_DLY2_MS 100
`define DICOND_DLY3_MS 1000
`define DICOND_REFRESH_US 6500
`define DICOND_REFRESH_CYC (`DICOND_REFRESH_US * `DICOND_CLK_MHZ)
`define DICOND_ADDR_CTRL 12'h000
`define DICOND_ADDR_PRM 12'h004
`define DICOND_ADDR_STAT 12'h008
`define DICOND_ADDR_CFG 12'h00C
`define DICOND_ADDR_CH0 12'h010
`endif

// >>> dicond_channel.v
// one input channel: on delay, off delay, inversion, fault qualification
`timescale 1ns/1ps
`include "dicond_consts.vh"
module dicond_channel (
  input wire clk,
  input wire rst,
  input wire ms_tick,
  input wire raw_in,
  input wire raw_fault,
  input wire [7:0] cfg,
  output reg status,
  output reg fault
);
  reg filt;
  reg [9:0] ms_cnt;
  wire lfd_en = cfg[`DICOND_CH_LFD];
  wire inv_en = cfg[`DICOND_CH_INV];
  wire [1:0] on_sel = cfg[`DICOND_CH_ON_LO +: 2];
  wire [1:0] off_sel = cfg[`DICOND_CH_OFF_LO +: 2];

  function [9:0] dly_ms;
    input [1:0] sel;
    begin
      case (sel)
        2'h1: dly_ms = 10'd`DICOND_DLY1_MS;
        2'h2: dly_ms = 10'd`DICOND_DLY2_MS;
        2'h3: dly_ms = 10'd`DICOND_DLY3_MS;
        default: dly_ms = 10'h000;
      endcase
    end
  endfunction

  wire [9:0] need = raw_in ? dly_ms(on_sel) : dly_ms(off_sel);

  always @(posedge clk) begin
    if (rst) begin
      filt <= 1'b0;
      ms_cnt <= 10'h000;
    end else if (raw_in == filt) begin
      ms_cnt <= 10'h000;
    end else if (need == 10'h000 || (ms_tick && ms_cnt + 10'd1 >= need)) begin
      filt <= raw_in;
      ms_cnt <= 10'h000;
    end else if (ms_tick) begin
      ms_cnt <= ms_cnt + 10'd1;
    end
  end

  // fault flag only while detection enabled
  always @(posedge clk) begin
    if (rst) begin
      status <= 1'b0;
      fault <= 1'b0;
    end else begin
      status <= filt ^ inv_en;
      fault <= lfd_en & raw_fault;
    end
  end
endmodule

// >>> dicond_props.sv
// port-level checker for the input conditioner
`timescale 1ns/1ps
module dicond_props (
  input wire CORE_CLK,
  input wire SYS_RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire [7:0] IN_BYTE1,
  input wire [7:0] IN_BYTE2,
  input wire IN_STROBE,
  input wire [7:0] CFG_CODE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_access; PSEL && PENABLE && !PREADY; endsequence
  sequence s_answer; PREADY ##1 !PREADY; endsequence
  property p_wait; s_access |=> s_answer; endproperty
  a_wait: assert property (p_wait) else $error("ready late or long");
  property p_prm_rd; PREADY && PSEL && !PWRITE && PADDR == 12'h004 |-> PSLVERR; endproperty
  a_prm_rd: assert property (p_prm_rd) else $error("byte port read not refused");
  property p_err_q; PSLVERR |-> PREADY && PSEL && PENABLE; endproperty
  a_err_q: assert property (p_err_q) else $error("error outside answer");
  property p_code_rd; PREADY && PSEL && !PWRITE && PADDR == 12'h00C |-> PRDATA[7:0] == 8'h11; endproperty
  a_code_rd: assert property (p_code_rd) else $error("code read wrong");
  // hold-off covers the release edges, where the code is still being loaded
  property p_code; !$past(SYS_RST) && !$past(SYS_RST, 2) && !$past(SYS_RST, 3) |-> CFG_CODE == 8'h11; endproperty
  a_code: assert property (p_code) else $error("code pin wrong");
  property p_pulse; IN_STROBE |=> !IN_STROBE [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("refresh pulse too dense");
  property p_hold; !IN_STROBE && !$past(SYS_RST) |-> $stable(IN_BYTE1) && $stable(IN_BYTE2); endproperty
  a_hold: assert property (p_hold) else $error("input bytes moved off refresh");
  property p_rst; $fell(SYS_RST) |-> IN_BYTE1 == 8'h00 && IN_BYTE2 == 8'h00 && !IN_STROBE; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
endmodule
bind dicond_top dicond_props i_props (.CORE_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY,
  .PSLVERR, .IN_BYTE1, .IN_BYTE2, .IN_STROBE, .CFG_CODE);

// >>> dicond_station.sv
// station unit model: takes the two input bytes at each refresh
`timescale 1ns/1ps
module dicond_station (
  input wire clk,
  input wire [7:0] cfg_code,
  input wire strobe,
  input wire [7:0] byte1,
  input wire [7:0] byte2
);
  localparam [7:0] SLOT_CODE = 8'h11;
  reg [15:0] image;
  integer n_frames = 0;
  always @(posedge clk) begin
    if (strobe && cfg_code === SLOT_CODE) begin
      image <= {byte2, byte1};
      n_frames <= n_frames + 1;
    end
  end
  // one slot, field timing left to the bench
endmodule

// >>> dicond_top_tb.sv
// self-checking bench for the input conditioner
`timescale 1ns/1ps
module dicond_top_tb;
  reg clk = 0;
  reg rst = 1;
  reg [7:0] din = 8'h00;
  reg [7:0] lf = 8'h00;
  reg psel = 0;
  reg penable = 0;
  reg pwrite = 0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  wire [31:0] prdata;
  wire pready, pslverr, in_strobe;
  wire [7:0] in_byte1, in_byte2, cfg_code;
  integer n_mismatch = 0, cmp_count = 0, seed = 9, i, k;
  reg [7:0] cfg [8];
  reg [7:0] tel [$];
  reg [31:0] rd;
  reg err, st_ok = 0, st_err = 0, st_seven = 0;
  always #2 clk = ~clk;
  dicond_top i_dut (.CORE_CLK(clk), .SYS_RST(rst), .DIN(din), .LINE_FAULT(lf), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IN_BYTE1(in_byte1), .IN_BYTE2(in_byte2), .IN_STROBE(in_strobe), .CFG_CODE(cfg_code));
  dicond_station i_station (.clk(clk), .cfg_code(cfg_code), .strobe(in_strobe), .byte1(in_byte1), .byte2(in_byte2));
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [7:0] d);
    integer t;
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      t = 0;
      do begin
        @(posedge clk);
        t = t + 1;
      end while (pready !== 1'b1 && t < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (t >= 20) n_mismatch = n_mismatch + 1;
    end
  endtask
  // telegram out, model updated only when every channel byte is legal
  task send(input [7:0] id);
    integer j, bad;
    reg [7:0] nb [8];
    begin
      apb(1'b1, 12'h004, id);
      bad = (id != 8'h18 && id != 8'h17);
      if (!bad) for (j = 0; j < tel.size(); j = j + 1) apb(1'b1, 12'h004, tel[j]);
      for (j = 0; j < 8 && !bad; j = j + 1) begin
        nb[j] = (id == 8'h18) ? tel[j] : {tel[2][7:1], (j < 7) ? tel[0][j] : 1'b0};
        if (nb[j][7:6] == 2'h3 || (nb[j][7:6] != 2'h0 && nb[j][0])) bad = 1;
      end
      st_err = bad;
      if (!bad) begin
        st_ok = 1;
        st_seven = (id == 8'h17);
        cfg = nb;
      end
    end
  endtask
  task check_all(input [7:0] smask);
    integer j;
    reg [31:0] e, m;
    begin
      m = {8'h00, 8'hFF, 8'h07, smask};
      e = {29'h0, st_seven, st_err, st_ok} << 8;
      for (j = 0; j < 8; j = j + 1) begin
        apb(1'b0, 12'h010 + 12'(4 * j), 8'h00);
        chk("chan cfg", {24'h000000, cfg[j]}, rd);
        e[j] = din[j] ^ cfg[j][1];
        e[16 + j] = lf[j] & cfg[j][0];
      end
      apb(1'b0, 12'h008, 8'h00);
      chk("stat", e & m, rd & m);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #80000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  initial begin
    for (k = 0; k < 8; k = k + 1) cfg[k] = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    din <= 8'($random(seed));
    lf <= 8'($random(seed));
    repeat (20) @(posedge clk);
    check_all(8'hFF);
    apb(1'b0, 12'h00C, 8'h00);
    chk("cfg code", 32'h00000011, rd);
    apb(1'b0, 12'h004, 8'h00);
    chk("prm read err", 32'h1, {31'h0, err});
    apb(1'b0, 12'hFF0, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("test reset and map done");
    for (k = 0; k < 5; k = k + 1) begin
      din <= 8'($random(seed));
      lf <= 8'($random(seed));
      tel = {};
      for (i = 0; i < 8; i = i + 1) tel.push_back(8'($random(seed)) & 8'h03);
      tel[6] = 8'h42;
      tel[7] = 8'h82;
      if (k == 1) tel[0] = 8'h41;
      if (k == 2) tel[3] = 8'hC0;
      if (k == 3) tel = {8'($random(seed)), 8'($random(seed)), tel[2]};
      send(k == 3 ? 8'h17 : (k == 4 ? 8'h19 : 8'h18));
      check_all(st_seven ? 8'h7F : 8'hFF);
      $display("test telegram %0d done", k);
    end
    tel = {8'h04, 8'h10, 8'h08, 8'h0C, 8'h20, 8'h30, 8'h00, 8'h00};
    din <= 8'h00;
    apb(1'b1, 12'h004, 8'h18);
    apb(1'b1, 12'h004, 8'hC3);
    // abort drops the half telegram, so the next id byte is not taken as data
    apb(1'b1, 12'h000, 8'h01);
    send(8'h18);
    apb(1'b0, 12'h010, 8'h00);
    chk("abort cfg", 32'h00000004, rd);
    repeat (30) @(posedge clk);
    din <= 8'hFF;
    repeat (300) @(posedge clk);
    apb(1'b0, 12'h008, 8'h00);
    chk("on delay status", 32'hF2, {24'h000000, rd[7:0]});
    din <= 8'h00;
    repeat (30) @(posedge clk);
    apb(1'b0, 12'h008, 8'h00);
    chk("off delay status", 32'h32, {24'h000000, rd[7:0]});
    $display("test delays done");
    // the run ends long before the first 6.5 ms refresh: no frame yet, bytes at reset
    chk("refresh frames", 32'h00000000, i_station.n_frames);
    chk("input byte 1", 32'h00000000, {24'h000000, in_byte1});
    chk("input byte 2", 32'h00000000, {24'h000000, in_byte2});
    chk("code pin", 32'h00000011, {24'h000000, cfg_code});
    $display("test refresh done");
    complete_run;
  end
endmodule
